// [hw/basic_timer_defs.svh]
// Constants for the basic timer: offsets, bit fields, reset values and timing
`ifndef BASIC_TIMER_DEFS_SVH
`define BASIC_TIMER_DEFS_SVH

// Register indices and byte addresses (index times four)
`define BT_IDX_MODE 10'h0D8
`define BT_IDX_COUNT 10'h0D9
`define BT_IDX_STATUS 10'h0E0
`define BT_IDX_MASK 10'h0E1
`define BT_ADDR_W 12
`define BT_ADDR_MODE 12'h360
`define BT_ADDR_COUNT 12'h364
`define BT_ADDR_STATUS 12'h380
`define BT_ADDR_MASK 12'h384

// Mode register fields
`define BT_MODE_RTC_SEL 0
`define BT_MODE_SIB_GREEN 1
`define BT_MODE_SIB_FAST 2
`define BT_MODE_SIB2_FAST 3
`define BT_MODE_RATE_LO 4
`define BT_MODE_RATE_HI 6
`define BT_MODE_RUN 7

// Status and mask fields
`define BT_IRQ_OVF 0

// Reset values
`define BT_MODE_RST 8'h00
`define BT_COUNT_RST 8'h00
`define BT_STATUS_RST 8'h00
`define BT_MASK_RST 8'h00

// Counting constants
`define BT_COUNT_MAX 8'hFF
`define BT_COUNT_ONE 8'h01
`define BT_PRESCALE_FULL 8'hFF
`define BT_STEPS_PER_PERIOD 256

// RTC timing: half second overflow from a 32768 Hz source
`define BT_RTC_PERIOD_MS 500
`define BT_RTC_SRC_HZ 32768
`define BT_RTC_TICKS_PER_PERIOD (`BT_RTC_SRC_HZ * `BT_RTC_PERIOD_MS / 1000)
`define BT_RTC_TICKS_PER_STEP (`BT_RTC_TICKS_PER_PERIOD / `BT_STEPS_PER_PERIOD)
`define BT_RTC_DIV_W 14

`endif

// [hw/basic_timer_pkg.sv]
// Types shared by the basic timer modules
package basic_timer_pkg;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MODE,
    SEL_COUNT,
    SEL_STATUS,
    SEL_MASK
  } reg_sel_t;

  typedef enum logic {
    SRC_PRESCALER,
    SRC_RTC
  } clk_src_t;

endpackage : basic_timer_pkg

// [hw/prescale_tick.sv]
// Prescaler that turns the CPU clock into timer steps
`timescale 1ns/1ns
`include "basic_timer_defs.svh"

module prescale_tick (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic [2:0] rate,
  // Step strobe
  output logic tick
);

  logic [7:0] div_cnt;

  // Divisor minus one: 255 for code 0 down to 1 for code 7
  function automatic logic [7:0] rate_mask(input logic [2:0] code);
    rate_mask = `BT_PRESCALE_FULL >> code;
  endfunction : rate_mask

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= `BT_COUNT_RST;
    end else if (ce) begin
      if (!run) begin
        div_cnt <= `BT_COUNT_RST;
      end else begin
        div_cnt <= div_cnt + `BT_COUNT_ONE;
      end
    end
  end

  assign tick = ce && run && ((div_cnt & rate_mask(rate)) == rate_mask(rate));

endmodule : prescale_tick

// [hw/rtc_step.sv]
// Divider on the RTC source giving count steps and a fixed half second overflow
`timescale 1ns/1ns
`include "basic_timer_defs.svh"

module rtc_step (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control and source
  input wire logic run,
  input wire logic src_tick,
  // Strobes
  output logic step,
  output logic period_done
);

  localparam logic [`BT_RTC_DIV_W-1:0] STEP_MASK =
    `BT_RTC_DIV_W'(`BT_RTC_TICKS_PER_STEP - 1);
  localparam logic [`BT_RTC_DIV_W-1:0] PERIOD_LAST =
    `BT_RTC_DIV_W'(`BT_RTC_TICKS_PER_PERIOD - 1);
  localparam logic [`BT_RTC_DIV_W-1:0] DIV_ONE = `BT_RTC_DIV_W'(1);

  logic [`BT_RTC_DIV_W-1:0] div_cnt;
  logic advance;

  assign advance = ce && run && src_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (ce) begin
      if (!run) begin
        div_cnt <= '0;
      end else if (src_tick) begin
        div_cnt <= div_cnt + DIV_ONE;
      end
    end
  end

  assign step = advance && ((div_cnt & STEP_MASK) == STEP_MASK);
  assign period_done = advance && (div_cnt == PERIOD_LAST);

endmodule : rtc_step

// [hw/basic_timer.sv]
// Basic 8-bit interval timer with RTC mode, APB registers and interrupt
//
// How it works
// - Counter runs up in 8 bits, wraps FF to 00, keeps counting; outside RTC mode the wrap raises overflow.
// - RTC mode overflows every half second regardless of the loaded count.
// - RTC mode ignores the prescaler rate field.
// - RTC exists only when built with the RTC option; else select is inert.
// - With the timer running, an overflow during green mode wakes the system.
// - Mode bit 0 picks prescaled CPU clock (0) or RTC source (1).
// - Mode bits 6..4 pick divisor 256 at code 0 halving to 2 at code 7.
// - Mode bit 7 stops (0) or runs (1) the counter.
// - Mode bit 1 enables green wake-up for the sibling timer/counter.
// - Mode bit 2 picks the sibling's internal clock: CPU or oscillator.
// - Mode bit 3 picks the second sibling's internal clock: CPU or oscillator.
// - Count register is 8-bit read/write; a write sets the running count.
// - A full period is 256 steps; outside RTC mode, preset P gives 256 minus P steps.
`timescale 1ns/1ns
`include "basic_timer_defs.svh"

module basic_timer #(
  parameter bit RTC_OPTION = 1'b1
) (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`BT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // RTC source strobe, one pclk cycle per source period
  input wire logic rtc_src_tick,
  // System power state
  input wire logic green_mode,
  // Interrupt and wake-up
  output logic irq,
  output logic wake_req,
  // Sibling timer controls
  output logic sibling_green_wake_en,
  output logic sibling_fast_clock_sel,
  output logic second_sibling_fast_clock_sel
);

  logic [7:0] timer0_mode_reg;
  logic [7:0] timer0_count_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;

  basic_timer_pkg::reg_sel_t sel;
  basic_timer_pkg::clk_src_t clk_src;

  logic setup_phase;
  logic wr_en;
  logic basic_timer_run;
  logic [2:0] basic_timer_prescale_sel;
  logic rtc_source_sel;
  logic pre_tick;
  logic rtc_tick_step;
  logic rtc_period;
  logic step;
  logic overflow;
  logic basic_timer_irq_flag;
  logic basic_timer_irq_enable;
  logic [7:0] next_count;
  logic [7:0] next_status;
  logic [31:0] next_rdata;

  // Register address decode
  function automatic basic_timer_pkg::reg_sel_t decode(input logic [`BT_ADDR_W-1:0] addr);
    if (addr == `BT_ADDR_MODE) begin
      decode = basic_timer_pkg::SEL_MODE;
    end else if (addr == `BT_ADDR_COUNT) begin
      decode = basic_timer_pkg::SEL_COUNT;
    end else if (addr == `BT_ADDR_STATUS) begin
      decode = basic_timer_pkg::SEL_STATUS;
    end else if (addr == `BT_ADDR_MASK) begin
      decode = basic_timer_pkg::SEL_MASK;
    end else begin
      decode = basic_timer_pkg::SEL_NONE;
    end
  endfunction : decode

  assign sel = decode(paddr);
  assign setup_phase = psel && !penable;
  assign wr_en = ce && psel && penable && pwrite;

  // Zero wait state slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == basic_timer_pkg::SEL_NONE);

  // Mode register fields
  assign basic_timer_run = timer0_mode_reg[`BT_MODE_RUN];
  assign basic_timer_prescale_sel = timer0_mode_reg[`BT_MODE_RATE_HI:`BT_MODE_RATE_LO];
  assign rtc_source_sel = timer0_mode_reg[`BT_MODE_RTC_SEL];
  assign sibling_green_wake_en = timer0_mode_reg[`BT_MODE_SIB_GREEN];
  assign sibling_fast_clock_sel = timer0_mode_reg[`BT_MODE_SIB_FAST];
  assign second_sibling_fast_clock_sel = timer0_mode_reg[`BT_MODE_SIB2_FAST];

  // Clock source choice; the RTC path exists only with the option built in
  assign clk_src = (RTC_OPTION && rtc_source_sel) ? basic_timer_pkg::SRC_RTC
                                                  : basic_timer_pkg::SRC_PRESCALER;

  // CPU clock prescaler, idle in RTC mode
  prescale_tick u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(basic_timer_run && (clk_src == basic_timer_pkg::SRC_PRESCALER)),
    .rate(basic_timer_prescale_sel),
    .tick(pre_tick)
  );

  // RTC divider with its own half second period
  rtc_step u_rtc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(basic_timer_run && (clk_src == basic_timer_pkg::SRC_RTC)),
    .src_tick(rtc_src_tick),
    .step(rtc_tick_step),
    .period_done(rtc_period)
  );

  // Step source and overflow detection
  always_comb begin
    if (clk_src == basic_timer_pkg::SRC_RTC) begin
      step = rtc_tick_step;
      overflow = basic_timer_run && rtc_period;
    end else begin
      step = pre_tick;
      overflow = basic_timer_run && pre_tick && (timer0_count_reg == `BT_COUNT_MAX);
    end
  end

  // Count update; a software write wins over a step
  always_comb begin
    next_count = timer0_count_reg;
    if (wr_en && (sel == basic_timer_pkg::SEL_COUNT)) begin
      next_count = pwdata[7:0];
    end else if (basic_timer_run && step) begin
      next_count = timer0_count_reg + `BT_COUNT_ONE;
    end
  end

  // Mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_mode_reg <= `BT_MODE_RST;
    end else if (wr_en && (sel == basic_timer_pkg::SEL_MODE)) begin
      timer0_mode_reg <= pwdata[7:0];
    end
  end

  // Count register, held while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_count_reg <= `BT_COUNT_RST;
    end else if (ce) begin
      timer0_count_reg <= next_count;
    end
  end

  // Sticky status; a new overflow wins over a write-one clear
  always_comb begin
    next_status = irq_status_reg;
    if (wr_en && (sel == basic_timer_pkg::SEL_STATUS)) begin
      next_status = irq_status_reg & ~pwdata[7:0];
    end
    if (overflow) begin
      next_status[`BT_IRQ_OVF] = 1'b1;
    end
    next_status[7:1] = 7'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= `BT_STATUS_RST;
    end else if (ce) begin
      irq_status_reg <= next_status;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `BT_MASK_RST;
    end else if (wr_en && (sel == basic_timer_pkg::SEL_MASK)) begin
      irq_mask_reg <= {7'h00, pwdata[`BT_IRQ_OVF]};
    end
  end

  assign basic_timer_irq_flag = irq_status_reg[`BT_IRQ_OVF];
  assign basic_timer_irq_enable = irq_mask_reg[`BT_IRQ_OVF];

  // Level interrupt while an unmasked status bit stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_status & irq_mask_reg) && basic_timer_irq_enable;
    end
  end

  // Wake-up pulse on an overflow in green mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else if (ce) begin
      wake_req <= overflow && green_mode && basic_timer_run;
    end
  end

  // Read data captured in the setup cycle
  always_comb begin
    next_rdata = 32'h00000000;
    case (sel)
      basic_timer_pkg::SEL_MODE: begin
        next_rdata = {24'h000000, timer0_mode_reg};
      end
      basic_timer_pkg::SEL_COUNT: begin
        next_rdata = {24'h000000, timer0_count_reg};
      end
      basic_timer_pkg::SEL_STATUS: begin
        next_rdata = {24'h000000, 7'h00, basic_timer_irq_flag};
      end
      basic_timer_pkg::SEL_MASK: begin
        next_rdata = {24'h000000, irq_mask_reg};
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && setup_phase && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule : basic_timer

// [verif/basic_timer_asserts.sv]
// Port checker for the basic timer
`timescale 1ns/1ns
`include "basic_timer_defs.svh"

module basic_timer_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`BT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic irq,
  input wire logic wake_req,
  input wire logic sibling_green_wake_en,
  input wire logic sibling_fast_clock_sel,
  input wire logic second_sibling_fast_clock_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {`BT_ADDR_MODE, `BT_ADDR_COUNT, `BT_ADDR_STATUS, `BT_ADDR_MASK};
  sequence mode_wr_s;
    psel && penable && pwrite && paddr == `BT_ADDR_MODE;
  endsequence
  sequence mask_off_s;
    psel && penable && pwrite && paddr == `BT_ADDR_MASK && !pwdata[0];
  endsequence
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready");
  bad_addr_a: assert property (pslverr == (psel && penable && !mapped))
    else $error("slave error wrong");
  rd_upper_a: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  sib_wake_a: assert property (mode_wr_s |=> sibling_green_wake_en == $past(pwdata[1]))
    else $error("sibling wake wrong");
  sib_fast_a: assert property (mode_wr_s |=> sibling_fast_clock_sel == $past(pwdata[2]))
    else $error("sibling clock wrong");
  sib2_fast_a: assert property (mode_wr_s |=> second_sibling_fast_clock_sel == $past(pwdata[3]))
    else $error("second sibling clock wrong");
  mask_off_a: assert property (mask_off_s |=> ##1 !irq)
    else $error("irq while masked");
  wake_pulse_a: assert property (wake_req |=> !wake_req)
    else $error("wake too long");
  stop_quiet_a: assert property (mode_wr_s ##0 !pwdata[7] |=> ##1 !wake_req [*8])
    else $error("wake while stopped");
  reset_val_a: assert property ($rose(presetn) |-> !irq && !wake_req && prdata == 32'h0)
    else $error("reset value wrong");
endmodule : basic_timer_asserts

bind basic_timer basic_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .wake_req(wake_req),
  .sibling_green_wake_en(sibling_green_wake_en), .sibling_fast_clock_sel(sibling_fast_clock_sel),
  .second_sibling_fast_clock_sel(second_sibling_fast_clock_sel));

// [verif/basic_timer_tb.sv]
// Self-checking testbench for the basic timer
`timescale 1ns/1ns
`include "basic_timer_defs.svh"

module basic_timer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`BT_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic rtc_src_tick = 1'b0;
  logic green_mode = 1'b0;
  logic ce = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, irq, wake_req, sib_wake, sib_fast, sib2_fast;
  logic err_seen;
  logic wake_seen = 1'b0;
  logic [31:0] rd;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  always #10 pclk = ~pclk;

  basic_timer #(.RTC_OPTION(1'b1)) u_basic_timer (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_src_tick(rtc_src_tick),
    .green_mode(green_mode), .irq(irq), .wake_req(wake_req), .sibling_green_wake_en(sib_wake),
    .sibling_fast_clock_sel(sib_fast), .second_sibling_fast_clock_sel(sib2_fast));

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) wake_seen <= 1'b1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [`BT_ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [`BT_ADDR_W-1:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input logic [`BT_ADDR_W-1:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask : rdchk

  task automatic t_reset();
    rdchk(`BT_ADDR_MODE, 32'h0);
    rdchk(`BT_ADDR_COUNT, 32'h0);
    rdchk(`BT_ADDR_STATUS, 32'h0);
    rdchk(`BT_ADDR_MASK, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(`BT_ADDR_MODE, 8'h0E);
    rdchk(`BT_ADDR_MODE, 32'h0E);
    chk({31'h0, sib_wake}, 32'h1);
    chk({31'h0, sib_fast}, 32'h1);
    chk({31'h0, sib2_fast}, 32'h1);
    wr(12'h368, 8'hFF);
    chk({31'h0, err_seen}, 32'h1);
    rdchk(12'h368, 32'h0);
    wr(`BT_ADDR_MODE, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_stop();
    wr(`BT_ADDR_MODE, 8'h70);
    wr(`BT_ADDR_COUNT, 8'hFF);
    repeat (40) @(posedge pclk);
    rdchk(`BT_ADDR_COUNT, 32'hFF);
    rdchk(`BT_ADDR_STATUS, 32'h0);
    $display("test stop done");
  endtask : t_stop

  task automatic t_freeze();
    wr(`BT_ADDR_MODE, 8'h00);
    wr(`BT_ADDR_COUNT, 8'h10);
    wr(`BT_ADDR_MODE, 8'hF0);
    ce <= 1'b0;
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    rdchk(`BT_ADDR_COUNT, 32'h10);
    wr(`BT_ADDR_MODE, 8'h00);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_rate();
    int d;
    wr(`BT_ADDR_MASK, 8'h01);
    for (int r = 0; r < 8; r++) begin
      d = 256 >> r;
      wr(`BT_ADDR_MODE, 8'h00);
      wr(`BT_ADDR_COUNT, 8'hFE);
      wr(`BT_ADDR_STATUS, 8'h01);
      wr(`BT_ADDR_MODE, 8'(8'h80 | (r << 4)));
      repeat (2 * d - 4) @(posedge pclk);
      rdchk(`BT_ADDR_STATUS, 32'h0);
      rdchk(`BT_ADDR_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(`BT_ADDR_STATUS, 8'h01);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test rate done");
  endtask : t_rate

  task automatic t_mask();
    wr(`BT_ADDR_MASK, 8'h00);
    wr(`BT_ADDR_MODE, 8'h00);
    wr(`BT_ADDR_COUNT, 8'hFE);
    wr(`BT_ADDR_MODE, 8'hF0);
    repeat (10) @(posedge pclk);
    rdchk(`BT_ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`BT_ADDR_MASK, 8'h01);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`BT_ADDR_MASK, 8'h00);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`BT_ADDR_MODE, 8'h00);
    wr(`BT_ADDR_STATUS, 8'h01);
    $display("test mask done");
  endtask : t_mask

  task automatic t_rtc();
    chk({31'h0, wake_seen}, 32'h0);
    wr(`BT_ADDR_COUNT, 8'hF0);
    green_mode <= 1'b1;
    rtc_src_tick <= 1'b1;
    wr(`BT_ADDR_MODE, 8'hF1);
    repeat (16000) @(posedge pclk);
    rdchk(`BT_ADDR_STATUS, 32'h0);
    rdchk(`BT_ADDR_COUNT, 32'hEA);
    repeat (800) @(posedge pclk);
    rdchk(`BT_ADDR_STATUS, 32'h1);
    chk({31'h0, wake_seen}, 32'h1);
    rtc_src_tick <= 1'b0;
    green_mode <= 1'b0;
    wr(`BT_ADDR_MODE, 8'h00);
    wr(`BT_ADDR_STATUS, 8'h01);
    rdchk(`BT_ADDR_STATUS, 32'h0);
    $display("test rtc done");
  endtask : t_rtc

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_stop();
    t_freeze();
    t_rate();
    t_mask();
    t_rtc();
    close_out();
  end
endmodule : basic_timer_tb
